// File: inc/hscr_pkg.sv
package hscr_pkg;

  // register selector carried between engine and bank
  localparam logic SEL_CFG = 1'b0;
  localparam logic SEL_HTR = 1'b1;

  // values after reset
  localparam logic [7:0] CFG_RESET = 8'h3A;
  localparam logic [3:0] HTR_LEVEL_RESET = 4'h0;
  localparam logic [3:0] HTR_UNUSED_READ = 4'h0;

  // field positions in measurement_config
  localparam int CFG_RES_HIGH_BIT = 7;
  localparam int CFG_SUPPLY_BIT = 6;
  localparam int CFG_HEATER_BIT = 2;
  localparam int CFG_RES_LOW_BIT = 0;
  localparam logic [2:0] CFG_UNUSED_HIGH_READ = 3'h7;
  localparam logic CFG_UNUSED_LOW_READ = 1'b1;

  // command bytes of the register access protocol
  localparam logic [7:0] CMD_WRITE_CFG = 8'hA0;
  localparam logic [7:0] CMD_READ_CFG = 8'hA1;
  localparam logic [7:0] CMD_WRITE_HTR = 8'hA2;
  localparam logic [7:0] CMD_READ_HTR = 8'hA3;

  // default 7-bit bus address, arbitrary value
  localparam logic [6:0] DEV_ADDR_DEF = 7'h40;

  // bits in one byte, counted on the link
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // result widths per resolution code
  localparam logic [4:0] RH_W00 = 5'h0C;
  localparam logic [4:0] RH_W01 = 5'h08;
  localparam logic [4:0] RH_W10 = 5'h0A;
  localparam logic [4:0] RH_W11 = 5'h0B;
  localparam logic [4:0] T_W00 = 5'h0E;
  localparam logic [4:0] T_W01 = 5'h0C;
  localparam logic [4:0] T_W10 = 5'h0D;
  localparam logic [4:0] T_W11 = 5'h0B;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_ACK   = 8'h04,
    ST_CMD   = 8'h08,
    ST_WDATA = 8'h10,
    ST_RDATA = 8'h20,
    ST_RACK  = 8'h40,
    ST_WAIT  = 8'h80
  } hscr_state_t;

  // humidity result width for a resolution code
  function automatic logic [4:0] hscr_rh_width(input logic [1:0] sel);
    case (sel)
      2'h0: hscr_rh_width = RH_W00;
      2'h1: hscr_rh_width = RH_W01;
      2'h2: hscr_rh_width = RH_W10;
      default: hscr_rh_width = RH_W11;
    endcase
  endfunction : hscr_rh_width

  // temperature result width for a resolution code
  function automatic logic [4:0] hscr_temp_width(input logic [1:0] sel);
    case (sel)
      2'h0: hscr_temp_width = T_W00;
      2'h1: hscr_temp_width = T_W01;
      2'h2: hscr_temp_width = T_W10;
      default: hscr_temp_width = T_W11;
    endcase
  endfunction : hscr_temp_width

  // command byte names a write
  function automatic logic hscr_is_write_cmd(input logic [7:0] cmd);
    hscr_is_write_cmd = (cmd == CMD_WRITE_CFG) || (cmd == CMD_WRITE_HTR);
  endfunction : hscr_is_write_cmd

  // command byte names a read
  function automatic logic hscr_is_read_cmd(input logic [7:0] cmd);
    hscr_is_read_cmd = (cmd == CMD_READ_CFG) || (cmd == CMD_READ_HTR);
  endfunction : hscr_is_read_cmd

endpackage : hscr_pkg

// File: inc/hscr_reg_if.sv
`timescale 1ns/1ps
interface hscr_reg_if;
  import hscr_pkg::*;
  logic wr_stb;
  logic wr_sel;
  logic [7:0] wr_data;
  logic rd_sel;
  logic [7:0] rd_data;

  modport engine (output wr_stb, output wr_sel, output wr_data, output rd_sel, input rd_data);
  modport bank (input wr_stb, input wr_sel, input wr_data, input rd_sel, output rd_data);
endinterface : hscr_reg_if

// File: src/hscr_bank.sv
`timescale 1ns/1ps
module hscr_bank
  import hscr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic supply_low_in,
  hscr_reg_if.bank rif,
  output logic [1:0] resolution_select_out,
  output logic heater_on_out,
  output logic [3:0] heater_level_out,
  output logic [4:0] rh_width_out,
  output logic [4:0] temp_width_out,
  output logic supply_low_flag_out
);

  logic supply_meta;
  logic [7:0] cfg_read;
  logic [7:0] htr_read;
  logic cfg_wr;
  logic htr_wr;
  logic [1:0] next_res;

  // write decode, only defined fields take data
  assign cfg_wr = rif.wr_stb && (rif.wr_sel == SEL_CFG);
  assign htr_wr = rif.wr_stb && (rif.wr_sel == SEL_HTR);
  assign next_res = {rif.wr_data[CFG_RES_HIGH_BIT], rif.wr_data[CFG_RES_LOW_BIT]};

  // read images; unused bits are constants, not storage
  assign cfg_read = {resolution_select_out[1], supply_low_flag_out, CFG_UNUSED_HIGH_READ,
                     heater_on_out, CFG_UNUSED_LOW_READ, resolution_select_out[0]};
  assign htr_read = {HTR_UNUSED_READ, heater_level_out};
  assign rif.rd_data = (rif.rd_sel == SEL_HTR) ? htr_read : cfg_read;

  // writable fields, held until reset or next write
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      resolution_select_out <= {CFG_RESET[CFG_RES_HIGH_BIT], CFG_RESET[CFG_RES_LOW_BIT]};
      heater_on_out <= CFG_RESET[CFG_HEATER_BIT];
      heater_level_out <= HTR_LEVEL_RESET;
      rh_width_out <= hscr_rh_width({CFG_RESET[CFG_RES_HIGH_BIT], CFG_RESET[CFG_RES_LOW_BIT]});
      temp_width_out <= hscr_temp_width({CFG_RESET[CFG_RES_HIGH_BIT], CFG_RESET[CFG_RES_LOW_BIT]});
    end else if (clk_en_in) begin
      if (cfg_wr) begin
        resolution_select_out <= next_res;
        heater_on_out <= rif.wr_data[CFG_HEATER_BIT];
        rh_width_out <= hscr_rh_width(next_res);
        temp_width_out <= hscr_temp_width(next_res);
      end
      if (htr_wr) begin
        heater_level_out <= rif.wr_data[3:0];
      end
    end
  end

  // supply monitor pin, two-flop synchroniser, read-only flag
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      supply_meta <= 1'b0;
      supply_low_flag_out <= 1'b0;
    end else if (clk_en_in) begin
      supply_meta <= supply_low_in;
      supply_low_flag_out <= supply_meta;
    end
  end

endmodule : hscr_bank

// File: src/hscr_top.sv
`timescale 1ns/1ps
module hscr_top
  import hscr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic supply_low_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [1:0] resolution_select_out,
  output logic heater_on_out,
  output logic [3:0] heater_level_out,
  output logic [4:0] rh_width_out,
  output logic [4:0] temp_width_out,
  output logic supply_low_flag_out
);

  hscr_reg_if rif ();

  logic scl_meta;
  logic scl_sync;
  logic scl_prev;
  logic sda_meta;
  logic sda_sync;
  logic sda_prev;
  hscr_state_t state;
  hscr_state_t after_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx_byte;
  logic cmd_sel;
  logic rd_pending;
  hscr_state_t next_state;
  hscr_state_t next_after;
  logic [3:0] next_cnt;
  logic [7:0] next_shreg;
  logic [7:0] next_tx;
  logic next_cmd_sel;
  logic next_rd_pending;
  logic next_oe;
  logic wr_go;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_done;
  logic addr_match;
  logic [7:0] rx_next;
  logic [3:0] cnt_inc;
  logic cmd_is_wr;
  logic cmd_is_rd;
  logic cmd_target;

  // line events seen through the synchronised copies
  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  assign bus_start = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign bus_stop = scl_sync && scl_prev && !sda_prev && sda_sync;
  assign byte_done = scl_fall && (bit_cnt == BYTE_BITS);

  // byte decode
  assign rx_next = {shreg[6:0], sda_sync};
  assign cnt_inc = bit_cnt + 4'h1;
  assign addr_match = (shreg[7:1] == DEV_ADDR);
  assign cmd_is_wr = hscr_is_write_cmd(shreg);
  assign cmd_is_rd = hscr_is_read_cmd(shreg);
  assign cmd_target = (shreg == CMD_WRITE_HTR) || (shreg == CMD_READ_HTR);

  // register bank access
  assign rif.wr_stb = wr_go;
  assign rif.wr_sel = cmd_sel;
  assign rif.wr_data = shreg;
  assign rif.rd_sel = cmd_sel;

  // link protocol, next-state logic
  always_comb begin
    next_state = state;
    next_after = after_ack;
    next_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx = tx_byte;
    next_cmd_sel = cmd_sel;
    next_rd_pending = rd_pending;
    next_oe = sda_oe_out;
    wr_go = 1'b0;
    if (bus_stop) begin
      next_state = ST_IDLE;
      next_oe = 1'b0;
    end else if (bus_start) begin
      next_state = ST_ADDR;
      next_cnt = 4'h0;
      next_oe = 1'b0;
    end else begin
      case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            next_shreg = rx_next;
            next_cnt = cnt_inc;
          end else if (byte_done) begin
            // a read address is answered only after a read command
            if (addr_match && (!shreg[0] || rd_pending)) begin
              next_oe = 1'b1;
              next_state = ST_ACK;
              next_after = shreg[0] ? ST_RDATA : ST_CMD;
              if (shreg[0]) begin
                next_tx = rif.rd_data;
                next_rd_pending = 1'b0;
              end
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
        ST_CMD: begin
          if (scl_rise) begin
            next_shreg = rx_next;
            next_cnt = cnt_inc;
          end else if (byte_done) begin
            // unknown command bytes are not acknowledged
            if (cmd_is_wr || cmd_is_rd) begin
              next_oe = 1'b1;
              next_state = ST_ACK;
              next_cmd_sel = cmd_target;
              next_rd_pending = cmd_is_rd;
              next_after = cmd_is_wr ? ST_WDATA : ST_WAIT;
            end else begin
              next_rd_pending = 1'b0;
              next_state = ST_WAIT;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            next_shreg = rx_next;
            next_cnt = cnt_inc;
          end else if (byte_done) begin
            wr_go = 1'b1;
            next_oe = 1'b1;
            next_state = ST_ACK;
            next_after = ST_WAIT;
          end
        end
        ST_ACK: begin
          // hold the acknowledge low through one clock pulse
          if (scl_fall) begin
            next_cnt = 4'h0;
            next_state = after_ack;
            next_oe = (after_ack == ST_RDATA) ? !tx_byte[7] : 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            next_cnt = cnt_inc;
          end else if (byte_done) begin
            next_oe = 1'b0;
            next_state = ST_RACK;
          end else if (scl_fall) begin
            next_tx = {tx_byte[6:0], 1'b0};
            next_oe = !tx_byte[6];
          end
        end
        ST_RACK: begin
          // one byte only, no checksum follows whatever the master answers
          if (scl_rise) begin
            next_state = ST_WAIT;
          end
        end
        ST_IDLE: begin
          next_oe = 1'b0;
        end
        ST_WAIT: begin
          next_oe = 1'b0;
        end
        default: begin
          next_state = ST_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // link pin synchronisers and edge history
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else if (clk_en_in) begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // protocol state registers
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_IDLE;
      after_ack <= ST_WAIT;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx_byte <= 8'h00;
      cmd_sel <= SEL_CFG;
      rd_pending <= 1'b0;
      sda_oe_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (clk_en_in) begin
      state <= next_state;
      after_ack <= next_after;
      bit_cnt <= next_cnt;
      shreg <= next_shreg;
      tx_byte <= next_tx;
      cmd_sel <= next_cmd_sel;
      rd_pending <= next_rd_pending;
      sda_oe_out <= next_oe;
      sda_out <= 1'b0; // open drain: only ever pulls low
    end
  end

  hscr_bank u_bank (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in),
    .supply_low_in(supply_low_in),
    .rif(rif.bank),
    .resolution_select_out(resolution_select_out),
    .heater_on_out(heater_on_out),
    .heater_level_out(heater_level_out),
    .rh_width_out(rh_width_out),
    .temp_width_out(temp_width_out),
    .supply_low_flag_out(supply_low_flag_out)
  );

endmodule : hscr_top

// File: tb/hscr_top_properties.sv
`timescale 1ns/1ps
module hscr_top_properties (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic scl_in,
  input wire logic supply_low_in,
  input wire logic sda_oe_out,
  input wire logic [1:0] resolution_select_out,
  input wire logic heater_on_out,
  input wire logic [3:0] heater_level_out,
  input wire logic [4:0] rh_width_out,
  input wire logic [4:0] temp_width_out,
  input wire logic supply_low_flag_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // expected widths for the current resolution code
  wire [1:0] rs = resolution_select_out;
  wire [4:0] exp_rh = rs[1] ? (rs[0] ? 5'h0B : 5'h0A) : (rs[0] ? 5'h08 : 5'h0C);
  wire [4:0] exp_t = rs[1] ? (rs[0] ? 5'h0B : 5'h0D) : (rs[0] ? 5'h0C : 5'h0E);
  wire [6:0] regs = {rs, heater_on_out, heater_level_out};
  // register outputs and their decodes
  AST_RESET_CFG: assert property ($rose(arst_n_in) |-> rs == 2'h0 && !heater_on_out)
    else $error("config outputs wrong after reset");
  AST_RESET_HTR: assert property ($rose(arst_n_in) |-> heater_level_out == 4'h0)
    else $error("heater level wrong after reset");
  AST_RH_WIDTH: assert property ($stable(rs) |-> rh_width_out == exp_rh)
    else $error("humidity width mismatch");
  AST_TEMP_WIDTH: assert property ($stable(rs) |-> temp_width_out == exp_t)
    else $error("temperature width mismatch");
  AST_SUPPLY_FLAG: assert property ((clk_en_in && $stable(supply_low_in))[*6]
    |-> supply_low_flag_out == supply_low_in) else $error("supply flag not following");
  AST_PERSIST: assert property (!$stable(regs) |-> $rose(sda_oe_out))
    else $error("register changed without a write");
  AST_FREEZE: assert property (!clk_en_in |=> $stable(regs) && $stable(sda_oe_out)
    && $stable(supply_low_flag_out)) else $error("state moved while clock enable low");
  AST_SCL_HOLD: assert property ($rose(scl_in) |=> $stable(sda_oe_out)[*4])
    else $error("data line changed while clock high");
  // main scenarios reached
  COV_HTR_MAX: cover property (heater_level_out == 4'hF);
  COV_SUPPLY: cover property ($rose(supply_low_flag_out));
  COV_RES3: cover property (rs == 2'h3 && heater_on_out);
endmodule : hscr_top_properties

bind hscr_top hscr_top_properties chk_u (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
  .clk_en_in(clk_en_in), .scl_in(scl_in), .supply_low_in(supply_low_in),
  .sda_oe_out(sda_oe_out), .resolution_select_out(resolution_select_out),
  .heater_on_out(heater_on_out), .heater_level_out(heater_level_out),
  .rh_width_out(rh_width_out), .temp_width_out(temp_width_out),
  .supply_low_flag_out(supply_low_flag_out));

// File: tb/hscr_host.sv
`timescale 1ns/1ps
module hscr_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_drv_out
);
  // bus idle: both lines released
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  // wait n system clocks, changes land off the sampling edge
  task automatic hold(input int n);
    repeat (n) @(negedge clk_in);
  endtask : hold
  // start or repeated start; long low phase lets the device release first
  task automatic start_cond();
    hold(1);
    sda_drv_out = 1'b1;
    hold(5);
    scl_out = 1'b1;
    hold(4);
    sda_drv_out = 1'b0;
    hold(4);
    scl_out = 1'b0;
  endtask : start_cond
  // stop, then bus left idle
  task automatic stop_cond();
    hold(1);
    sda_drv_out = 1'b0;
    hold(3);
    scl_out = 1'b1;
    hold(4);
    sda_drv_out = 1'b1;
    hold(4);
  endtask : stop_cond
  // eight bits msb first plus acknowledge, 160 ns per bit
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      hold(1);
      sda_drv_out = tx[i];
      hold(3);
      scl_out = 1'b1;
      hold(4);
      rx[i] = sda_in;
      scl_out = 1'b0;
    end
  endtask : byte_io
endmodule : hscr_host

// File: tb/tb_hscr_top.sv
`timescale 1ns/1ps
module tb_hscr_top;
  import hscr_pkg::*;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic supply_low_in = 1'b0;
  logic scl, sda_drv, sda_oe, sda_out, heat_on, flag, s;
  logic [1:0] res;
  logic [3:0] heat_lvl;
  logic [4:0] rh_w, t_w;
  logic [7:0] d, w, h;
  logic [8:0] ack;
  logic [4:0] rh_tab [4] = '{5'h0C, 5'h08, 5'h0A, 5'h0B};
  logic [4:0] t_tab [4] = '{5'h0E, 5'h0C, 5'h0D, 5'h0B};
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'h78EC;
  // open-drain wire with pull-up, device drives its sda_out level when enabled
  wire sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);
  always #10 sys_clk_in = ~sys_clk_in;
  hscr_host host_u (.clk_in(sys_clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_drv_out(sda_drv));
  hscr_top dut_u (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
    .scl_in(scl), .sda_in(sda_wire), .supply_low_in(supply_low_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe), .resolution_select_out(res), .heater_on_out(heat_on),
    .heater_level_out(heat_lvl), .rh_width_out(rh_w), .temp_width_out(t_w),
    .supply_low_flag_out(flag));
  // expected read image of the config register
  function automatic logic [7:0] cfg_img(input logic [7:0] v, input logic f);
    return {v[7], f, 3'h7, v[2], 1'b1, v[0]};
  endfunction : cfg_img
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] cmd, input logic [7:0] v);
    logic [8:0] r;
    logic [7:0] b [3];
    b = '{{DEV_ADDR_DEF, 1'b0}, cmd, v};
    host_u.start_cond();
    foreach (b[i]) begin
      host_u.byte_io({b[i], 1'b1}, r);
      check({15'h0, r[0]}, 16'h0);
    end
    host_u.stop_cond();
  endtask : wr
  // register read; with more set the host acks and clocks one extra byte
  task automatic rd(input logic [7:0] cmd, input logic more, output logic [7:0] v);
    logic [8:0] r;
    host_u.start_cond();
    host_u.byte_io({DEV_ADDR_DEF, 2'b01}, r);
    check({15'h0, r[0]}, 16'h0);
    host_u.byte_io({cmd, 1'b1}, r);
    check({15'h0, r[0]}, 16'h0);
    host_u.start_cond();
    host_u.byte_io({DEV_ADDR_DEF, 2'b11}, r);
    check({15'h0, r[0]}, 16'h0);
    host_u.byte_io({8'hFF, ~more}, r);
    v = r[8:1];
    if (more) begin
      host_u.byte_io(9'h1FF, r);
      check({8'h0, r[8:1]}, 16'h00FF);
    end
    host_u.stop_cond();
  endtask : rd
  task automatic reset_and_check();
    logic [7:0] v;
    arst_n_in = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    rd(CMD_READ_CFG, 1'b0, v);
    check({8'h0, v}, 16'h003A);
    rd(CMD_READ_HTR, 1'b1, v);
    check({8'h0, v}, 16'h0000);
  endtask : reset_and_check
  // hang guard
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    reset_and_check();
    for (int i = 0; i < 8; i++) begin
      w = 8'($random(seed));
      w[7] = i[1];
      w[0] = i[0];
      h = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      s = 1'($random(seed));
      supply_low_in = s;
      wr(CMD_WRITE_CFG, w);
      wr(CMD_WRITE_HTR, h);
      rd(CMD_READ_CFG, 1'b0, d);
      check({8'h0, d}, {8'h0, cfg_img(w, s)});
      rd(CMD_READ_HTR, 1'b0, d);
      check({8'h0, d}, {12'h0, h[3:0]});
      check({6'h0, rh_w, t_w}, {6'h0, rh_tab[{w[7], w[0]}], t_tab[{w[7], w[0]}]});
      check({11'h0, heat_on, heat_lvl}, {11'h0, w[2], h[3:0]});
      check({15'h0, flag}, {15'h0, s});
    end
    // refused requests: foreign address, read address with no read command pending
    host_u.start_cond();
    host_u.byte_io({~DEV_ADDR_DEF, 2'b01}, ack);
    check({15'h0, ack[0]}, 16'h1);
    host_u.start_cond();
    host_u.byte_io({DEV_ADDR_DEF, 2'b11}, ack);
    check({15'h0, ack[0]}, 16'h1);
    host_u.stop_cond();
    rd(CMD_READ_CFG, 1'b0, d);
    wr(CMD_WRITE_CFG, d ^ 8'h04);
    check({15'h0, heat_on}, {15'h0, ~d[2]});
    // supply pin moves while frozen; flag must wait for the enable
    clk_en_in = 1'b0;
    supply_low_in = ~s;
    repeat (10) @(negedge sys_clk_in);
    check({15'h0, flag}, {15'h0, s});
    clk_en_in = 1'b1;
    rd(CMD_READ_CFG, 1'b0, w);
    check({8'h0, w}, {8'h0, d ^ 8'h44});
    supply_low_in = 1'b0;
    reset_and_check();
    tally_and_finish();
  end
endmodule : tb_hscr_top
